// file: common/gpio_consts.vh
/*
  Register offsets, field positions and reset values of the
  twelve pin general purpose port.
  Assumes byte addressing on a 32-bit register bus.
*/
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH

// Byte offsets of the two registers
`define CFG_OFS 12'h1E0
`define DD_OFS 12'h1E4

// Configuration register fields
`define DRV_LSB 0
`define POL8_BIT 12
`define POL9_BIT 13
`define EVOE_LSB 14

// Data and direction register fields
`define VAL_LSB 0
`define DIR_LSB 16

// Pins that can carry clock compare events
`define EVT_PIN_A 8
`define EVT_PIN_B 9

// Reset values
`define DRV_RST 12'h000
`define POL_RST 1'b1
`define EVOE_RST 2'h0
`define DIR_RST 12'h000
`define VAL_RST 12'h000

// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hw/gpio_pin_driver.v
/*
  Per-pin output driver: turns direction, level and driver type
  into a pin value and output enable.
  Assumes the caller registers the results before they reach pins.
*/
`timescale 1ns/100ps

module gpio_pin_driver #(
  parameter NPIN = 12
) (
  // Effective direction, 1 = output
  input wire [NPIN-1:0] dir,
  // Level the pin should show
  input wire [NPIN-1:0] level,
  // Driver type, 0 = open drain, 1 = push-pull
  input wire [NPIN-1:0] push_pull,
  // Pin drive
  output reg [NPIN-1:0] drv_out,
  output reg [NPIN-1:0] drv_oe
);

  integer i;

  // Per pin drive selection
  always @* begin
    drv_out = {NPIN{1'b0}};
    drv_oe = {NPIN{1'b0}};
    for (i = 0; i < NPIN; i = i + 1) begin
      if (push_pull[i]) begin
        // Push-pull drives either level
        drv_out[i] = level[i];
        drv_oe[i] = dir[i];
      end else begin
        // Open drain pulls low or releases
        drv_out[i] = 1'b0;
        drv_oe[i] = dir[i] & ~level[i];
      end
    end
  end

endmodule // gpio_pin_driver

// file: hw/twelve_pin_gpio_port.v
/*
  Twelve pin general purpose port with AXI4-Lite register access,
  per pin direction, value and driver type, and clock compare
  event output on pins 8 and 9.
  Assumes pin inputs are asynchronous and the event inputs come
  from logic on aclk. The pad combines out and oe into a wire.
*/
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "gpio_consts.vh"

module twelve_pin_gpio_port #(
  parameter NPIN = 12,
  parameter AW = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address channel
  input wire [AW-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  // Write data channel
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // Write response channel
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // Read address channel
  input wire [AW-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  // Read data channel
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Clock compare events, active high
  input wire event_pin8,
  input wire event_pin9,
  // Pins
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out,
  output reg [NPIN-1:0] pin_oe
);

  // Configuration fields
  reg [NPIN-1:0] pin_driver_type_ff; // 1 = push-pull
  reg event_out_polarity_pin8_ff; // Pin 8 event polarity
  reg event_out_polarity_pin9_ff; // Pin 9 event polarity
  reg [1:0] event_oe_ff; // Event output enables, pins 9:8

  // Data and direction fields
  reg [NPIN-1:0] pin_direction_bits_ff; // 1 = output
  reg [NPIN-1:0] pin_value_ff; // Last written values

  // Pin input synchroniser
  reg [NPIN-1:0] pin_sync1_ff; // First stage, read by second only
  reg [NPIN-1:0] pin_sync2_ff; // Stable sampled level

  // Write channel bookkeeping
  reg [AW-1:0] aw_addr_ff; // Captured write address
  reg aw_got_ff; // Write address held
  reg [31:0] w_data_ff; // Captured write data
  reg [3:0] w_strb_ff; // Captured byte enables
  reg w_got_ff; // Write data held

  // Derived pin control
  reg [NPIN-1:0] pin_direction; // Effective direction
  reg [NPIN-1:0] eff_level; // Level each pin should show
  wire [NPIN-1:0] nxt_pin_out; // Driver value
  wire [NPIN-1:0] nxt_pin_oe; // Driver enable
  wire evt_level8; // Pin 8 event level
  wire evt_level9; // Pin 9 event level

  // Register images and their write merges
  reg [31:0] cfg_img; // Configuration image, reserved bits zero
  reg [31:0] dd_img; // Data and direction image, stored values
  reg [31:0] cfg_merged; // Configuration image after held write
  reg [31:0] dd_merged; // Data and direction image after held write

  // Merge a write into a word under byte enables
  function [31:0] merge_strb;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] strb;
    integer b;
    begin
      merge_strb = old_w;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_strb[b*8 +: 8] = new_w[b*8 +: 8];
        end
      end
    end
  endfunction

  // Address decode, bit 0 = configuration, bit 1 = data/direction
  function [1:0] reg_sel;
    input [AW-1:0] addr;
    begin
      reg_sel = 2'h0;
      if ({addr[AW-1:2], 2'h0} == `CFG_OFS) begin
        reg_sel = 2'h1;
      end else if ({addr[AW-1:2], 2'h0} == `DD_OFS) begin
        reg_sel = 2'h2;
      end
    end
  endfunction

  // Register images and write merges, built from the fields directly
  // so that the process sees every field it reads
  always @* begin
    cfg_img = 32'h0000_0000;
    cfg_img[`DRV_LSB +: NPIN] = pin_driver_type_ff;
    cfg_img[`POL8_BIT] = event_out_polarity_pin8_ff;
    cfg_img[`POL9_BIT] = event_out_polarity_pin9_ff;
    cfg_img[`EVOE_LSB +: 2] = event_oe_ff;
    dd_img = 32'h0000_0000;
    dd_img[`DIR_LSB +: NPIN] = pin_direction_bits_ff;
    dd_img[`VAL_LSB +: NPIN] = pin_value_ff;
    cfg_merged = merge_strb(cfg_img, w_data_ff, w_strb_ff);
    dd_merged = merge_strb(dd_img, w_data_ff, w_strb_ff);
  end

  // Data and direction image with stored direction and the given values
  function [31:0] dd_word;
    input [NPIN-1:0] val;
    begin
      dd_word = 32'h0000_0000;
      dd_word[`DIR_LSB +: NPIN] = pin_direction_bits_ff;
      dd_word[`VAL_LSB +: NPIN] = val;
    end
  endfunction

  // Event level: polarity 0 inverts, polarity 1 passes
  assign evt_level8 = event_out_polarity_pin8_ff ? event_pin8 : ~event_pin8;
  assign evt_level9 = event_out_polarity_pin9_ff ? event_pin9 : ~event_pin9;

  // Effective direction and level per pin
  always @* begin
    pin_direction = pin_direction_bits_ff;
    eff_level = pin_value_ff;
    if (event_oe_ff[0]) begin
      // Event enable overrides direction on pin 8
      pin_direction[`EVT_PIN_A] = 1'b1;
      eff_level[`EVT_PIN_A] = evt_level8;
    end
    if (event_oe_ff[1]) begin
      // Event enable overrides direction on pin 9
      pin_direction[`EVT_PIN_B] = 1'b1;
      eff_level[`EVT_PIN_B] = evt_level9;
    end
  end

  // Driver type applies to event pins too
  gpio_pin_driver #(
    .NPIN(NPIN)
  ) u_drv (
    .dir(pin_direction),
    .level(eff_level),
    .push_pull(pin_driver_type_ff),
    .drv_out(nxt_pin_out),
    .drv_oe(nxt_pin_oe)
  );

  // Register pin drive
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe <= {NPIN{1'b0}};
    end else begin
      pin_out <= nxt_pin_out;
      pin_oe <= nxt_pin_oe;
    end
  end

  // Two stage input synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync1_ff <= {NPIN{1'b0}};
      pin_sync2_ff <= {NPIN{1'b0}};
    end else begin
      pin_sync1_ff <= pin_in;
      pin_sync2_ff <= pin_sync1_ff;
    end
  end

  // Write path and register storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_ff <= {AW{1'b0}};
      aw_got_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      w_got_ff <= 1'b0;
      pin_driver_type_ff <= `DRV_RST;
      event_out_polarity_pin8_ff <= `POL_RST;
      event_out_polarity_pin9_ff <= `POL_RST;
      event_oe_ff <= `EVOE_RST;
      pin_direction_bits_ff <= `DIR_RST;
      pin_value_ff <= `VAL_RST;
    end else begin
      // Take write address
      if (awvalid && awready) begin
        aw_addr_ff <= awaddr;
        aw_got_ff <= 1'b1;
        awready <= 1'b0;
      end
      // Take write data
      if (wvalid && wready) begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
        w_got_ff <= 1'b1;
        wready <= 1'b0;
      end
      // Both halves held: perform the write
      if (aw_got_ff && w_got_ff && !bvalid) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        case (reg_sel(aw_addr_ff))
          2'h1: begin
            // Configuration register, reserved bits dropped
            pin_driver_type_ff <= cfg_merged[`DRV_LSB +: NPIN];
            event_out_polarity_pin8_ff <= cfg_merged[`POL8_BIT];
            event_out_polarity_pin9_ff <= cfg_merged[`POL9_BIT];
            event_oe_ff <= cfg_merged[`EVOE_LSB +: 2];
          end
          2'h2: begin
            // Data and direction, values always stored
            pin_direction_bits_ff <= dd_merged[`DIR_LSB +: NPIN];
            pin_value_ff <= dd_merged[`VAL_LSB +: NPIN];
          end
          default: begin
            // Unmapped address
            bresp <= `RESP_SLVERR;
          end
        endcase
      end
      // Response taken, reopen both channels
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        // Capture read data at the address handshake
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case (reg_sel(araddr))
          2'h1: begin
            rdata <= cfg_img;
          end
          2'h2: begin
            // Outputs return stored value, inputs live level
            rdata <= dd_word((pin_value_ff & pin_direction)
              | (pin_sync2_ff & ~pin_direction));
          end
          default: begin
            // Unmapped address reads zero with error
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      // Data taken, accept next address
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // twelve_pin_gpio_port

// file: verif/gpio_port_properties.sv
/* Bus timing and readback checks for the gpio port.
   Sees only the top ports; bound at the foot. */
`timescale 1ns/100ps
module gpio_port_properties #(
  parameter AW = 12
) (
  // Clock, reset
  input wire aclk,
  input wire aresetn,
  // Write side
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  // Read side
  input wire [AW-1:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read address taken this edge
  wire ar_hs = arvalid && arready;
  wire [9:0] ar_w = araddr[11:2];
  rd_latency_a: assert property (ar_hs |=> rvalid) else $error("read answer late");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer not held");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  ar_block_a: assert property (rvalid |-> !arready) else $error("second read taken");
  rd_unmapped_a: assert property (ar_hs && ar_w != 10'h078 && ar_w != 10'h079
    |=> rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read answered");
  dd_reserved_a: assert property (ar_hs && ar_w == 10'h079 |=> rresp == 2'h0 &&
    rdata[31:28] == 4'h0 && rdata[15:12] == 4'h0) else $error("reserved bits set");
  cfg_upper_a: assert property (ar_hs && ar_w == 10'h078 |=> rdata[31:16] == 16'h0)
    else $error("config upper bits set");
endmodule // gpio_port_properties

bind twelve_pin_gpio_port gpio_port_properties #(.AW(AW)) chk (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready);

// file: verif/pin_world.sv
/* Outside circuitry on the twelve pins.
   A pad nobody drives is pulled up. */
`timescale 1ns/100ps
module pin_world (
  // Device drive
  input wire [11:0] pin_out,
  input wire [11:0] pin_oe,
  // Outside drivers
  input wire [11:0] ext_val,
  input wire [11:0] ext_oe,
  // Pad level
  output wire [11:0] pin_in
);
  // Device wins, then outside, then pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_oe & ext_val) | ~ext_oe));
endmodule // pin_world

// file: verif/testbench.sv
/* Random register and pin traffic for the gpio port.
   Needs pin_world and the bound checker. */
`timescale 1ns/100ps
module testbench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0, ext_val = 12'h0, ext_oe = 12'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] wstrb = 4'hF;
  logic event_pin8 = 1'h0, event_pin9 = 1'h0;
  logic [31:0] wdata = 32'h0, cfg, dd, rv;
  logic [11:0] dir, lvl, oe, pad;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] pin_in, pin_out, pin_oe;
  int error_cnt = 0, check_count = 0, i;
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  twelve_pin_gpio_port uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .event_pin8,
    .event_pin9, .pin_in, .pin_out, .pin_oe);
  pin_world world (.pin_out, .pin_oe, .ext_val, .ext_oe, .pin_in);
  // Verdict and end of run
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Word compare
  task automatic chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bus write, waits for the answer
  task automatic wr(input [11:0] a, input [31:0] d, output [1:0] r);
    int n;
    logic ha, hw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (bvalid) begin
        r = bresp;
        break;
      end
      ha = awready;
      hw = wready;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    @(posedge aclk);
    bready <= 1'h0;
    if (n == 40) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // Bus read, waits for the answer
  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    int n;
    logic ha;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
      ha = arready;
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    @(posedge aclk);
    rready <= 1'h0;
    if (n == 40) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // Expected direction, level and drive enable
  function automatic void exp_pins(input [31:0] c, input [31:0] d, input [1:0] e,
    output [11:0] dr, output [11:0] lv, output [11:0] o);
    dr = d[27:16] | {2'h0, c[15:14], 8'h0};
    lv = d[11:0];
    if (c[14]) lv[8] = c[12] ? e[0] : ~e[0];
    if (c[15]) lv[9] = c[13] ? e[1] : ~e[1];
    o = dr & (c[11:0] | ~lv);
  endfunction
  // Main sequence
  initial begin
    void'($urandom(32'hDB402D3B));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h1E0, rv, rs);
    chk(rv, 32'h00003000);
    rd(12'h1E4, rv, rs);
    chk(rv, 32'h00000FFF);
    chk({20'h0, pin_oe}, 32'h0);
    rd(12'h1E8, rv, rs);
    chk({rv[29:0], rs}, 32'h2);
    wr(12'h1EC, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, 32'h2);
    for (i = 0; i < 60; i++) begin
      cfg = $urandom;
      dd = $urandom;
      @(posedge aclk);
      {event_pin9, event_pin8} <= 2'($urandom);
      ext_val <= 12'($urandom);
      ext_oe <= 12'($urandom);
      wr(12'h1E0, cfg, rs);
      chk({30'h0, rs}, 32'h0);
      wr(12'h1E4, dd, rs);
      chk({30'h0, rs}, 32'h0);
      repeat (4) @(posedge aclk);
      exp_pins(cfg, dd, {event_pin9, event_pin8}, dir, lvl, oe);
      pad = (oe & lvl) | (~oe & ((ext_oe & ext_val) | ~ext_oe));
      chk({20'h0, pin_oe}, {20'h0, oe});
      chk({20'h0, pin_out & oe}, {20'h0, lvl & oe});
      rd(12'h1E4, rv, rs);
      chk(rv, {4'h0, dd[27:16], 4'h0, (dir & dd[11:0]) | (~dir & pad)});
      rd(12'h1E0, rv, rs);
      chk(rv, cfg & 32'h0000FFFF);
    end
    // Corner: low byte lanes only, values cleared, direction kept
    @(posedge aclk);
    wstrb <= 4'h3;
    wr(12'h1E4, 32'h0, rs);
    chk({30'h0, rs}, 32'h0);
    @(posedge aclk);
    wstrb <= 4'hF;
    repeat (4) @(posedge aclk);
    dd = {dd[31:16], 16'h0};
    exp_pins(cfg, dd, {event_pin9, event_pin8}, dir, lvl, oe);
    pad = (oe & lvl) | (~oe & ((ext_oe & ext_val) | ~ext_oe));
    chk({20'h0, pin_oe}, {20'h0, oe});
    rd(12'h1E4, rv, rs);
    chk(rv, {4'h0, dd[27:16], 4'h0, (dir & dd[11:0]) | (~dir & pad)});
    stop_test();
  end
endmodule // testbench
